//--- rtl/pedc_top.sv
/*
 PHY energy-detect control register and power manager.
 Assumes a plain register port; energy and link inputs come from the
 analog front end, asynchronous to i_clk.
*/
`timescale 1ns/100ps
module pedc_top
   import pedc_pkg::*;
#(
   parameter int unsigned WINDOW_CYC = ENERGY_WINDOW_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // Front end status, asynchronous
   input wire logic i_energy_raw,
   input wire logic i_link_raw,
   input wire logic i_speed_100,
   // Transmit hold-off
   input wire logic i_transmit_request,
   output logic o_transmit_grant,
   // Front end controls
   output logic o_phy_power_on,
   output logic o_thres_low,
   output logic o_link_up,
   // Interrupt
   output logic o_irq
);
   logic rst_meta;
   logic rst_n;
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic energy_s;
   logic link_s;
   logic speed_s;
   logic energy_seen;
   logic prev_seen;
   logic prev_link;
   pedc_req_s req;
   pedc_ctrl_s ctrl;
   pedc_ctrl_s next_ctrl;
   pedc_pwr_e pwr;
   pedc_pwr_e next_pwr;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] next_irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] next_irq_mask;
   logic [IRQ_W-1:0] events;
   logic [15:0] rdata;
   logic [15:0] next_rdata;
   logic link_up;
   logic grant;
   logic next_grant;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Two-flop synchronisers; only the second stage is read
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {i_speed_100, i_link_raw, i_energy_raw};
         sync_b <= sync_a;
      end
   end
   assign energy_s = sync_b[0];
   assign link_s = sync_b[1];
   assign speed_s = sync_b[2];

   pedc_energy_window #(
      .WINDOW_CYC(WINDOW_CYC)
   ) pedc_energy_window_inst (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_energy(energy_s),
      .o_seen(energy_seen)
   );

   assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // Forced link only counts at 100 Mbps; the speed gate keeps it off at 10 Mbps
   assign link_up = (ctrl.force_link & speed_s) | link_s;

   // Control bits: only the three writable fields store
   always_comb begin
      next_ctrl = ctrl;
      if (req.wr && req.addr == OFS_CONTROL) begin
         next_ctrl.pwrdn_en = req.wdata[BIT_PWRDN_EN];
         next_ctrl.thres_low = req.wdata[BIT_THRES_LOW];
         next_ctrl.force_link = req.wdata[BIT_FORCE_LINK];
         // Energy flag and reserved bits are dropped here
      end
   end

   // Power state follows the energy flag only while enabled
   always_comb begin
      next_pwr = pwr;
      case (pwr)
         PEDC_ACTIVE: begin
            if (ctrl.pwrdn_en && !energy_seen) begin
               next_pwr = PEDC_ASLEEP;
            end
         end
         PEDC_ASLEEP: begin
            if (!ctrl.pwrdn_en || energy_seen) begin
               next_pwr = PEDC_ACTIVE;
            end
         end
         default: next_pwr = PEDC_ACTIVE;
      endcase
   end

   // Transmit grant waits for a link; asleep and unlinked it never comes
   always_comb begin
      next_grant = i_transmit_request && link_up && (pwr == PEDC_ACTIVE);
   end

   // Events: energy edges and link changes
   assign events[IRQ_ENERGY_RISE] = energy_seen & ~prev_seen;
   assign events[IRQ_ENERGY_FALL] = ~energy_seen & prev_seen;
   assign events[IRQ_LINK_CHANGE] = link_up ^ prev_link;

   // Sticky status, cleared by a read; a new event wins over the clear
   always_comb begin
      next_irq_stat = irq_stat;
      next_irq_mask = irq_mask;
      if (req.rd && req.addr == OFS_IRQ_STATUS) begin
         next_irq_stat = '0;
      end
      next_irq_stat = next_irq_stat | events;
      if (req.wr && req.addr == OFS_IRQ_MASK) begin
         next_irq_mask = req.wdata[IRQ_W-1:0];
      end
   end

   // Read mux; unmapped addresses and reserved bits read zero
   always_comb begin
      next_rdata = 16'h0000;
      if (req.rd) begin
         case (req.addr)
            OFS_CONTROL: begin
               next_rdata[BIT_PWRDN_EN] = ctrl.pwrdn_en;
               next_rdata[BIT_THRES_LOW] = ctrl.thres_low;
               next_rdata[BIT_FORCE_LINK] = ctrl.force_link;
               next_rdata[BIT_ENERGY_SEEN] = energy_seen;
            end
            OFS_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_stat;
            OFS_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
            OFS_LINK_STATE: next_rdata[2:0] = {(pwr == PEDC_ASLEEP), speed_s, link_up};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   // Control and power state; power-on clears every writable bit
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= '0;
         pwr <= PEDC_ACTIVE;
         grant <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         pwr <= next_pwr;
         grant <= next_grant;
      end
   end

   // Interrupt state; flag history resets high like the flag, so no false edge
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= IRQ_RESET;
         irq_mask <= IRQ_RESET;
         prev_seen <= 1'b1;
         prev_link <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         prev_seen <= energy_seen;
         prev_link <= link_up;
      end
   end

   // Read data stands for one cycle after the strobe, zero otherwise
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign o_rdata = rdata;
   assign o_phy_power_on = (pwr == PEDC_ACTIVE);
   assign o_thres_low = ctrl.thres_low;
   assign o_link_up = link_up;
   assign o_transmit_grant = grant;
   assign o_irq = |(irq_stat & irq_mask);
endmodule

//--- rtl/pedc_pkg.sv
/*
 Package for the PHY energy-detect control block: register offsets, field
 positions, reset values, timing counts and the carrier structs.
 Assumes a 40 MHz core clock; nothing else is needed from the surroundings.
*/
package pedc_pkg;
   // Clock rate and the energy-seen window
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned ENERGY_WINDOW_MS = 256;
   localparam int unsigned ENERGY_WINDOW_CYC = (CLK_HZ / 1000) * ENERGY_WINDOW_MS;

   // Register offsets (word index on the plain register port)
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h1;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h2;
   localparam logic [3:0] OFS_LINK_STATE = 4'h3;

   // Control register field positions
   localparam int unsigned BIT_PWRDN_EN = 13;
   localparam int unsigned BIT_THRES_LOW = 11;
   localparam int unsigned BIT_FORCE_LINK = 2;
   localparam int unsigned BIT_ENERGY_SEEN = 1;

   // Writable bits of the control register; all others but the energy flag at bit 1 read back as zero
   localparam logic [15:0] CONTROL_WR_MASK = 16'h2804;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;

   // Interrupt status bits
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_ENERGY_RISE = 0;
   localparam int unsigned IRQ_ENERGY_FALL = 1;
   localparam int unsigned IRQ_LINK_CHANGE = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } pedc_req_s;

   // Controls held for the analog front end
   typedef struct packed {
      logic pwrdn_en;
      logic thres_low;
      logic force_link;
   } pedc_ctrl_s;

   // Power state of the PHY
   typedef enum logic [1:0] {
      PEDC_ACTIVE,
      PEDC_ASLEEP
   } pedc_pwr_e;
endpackage

//--- rtl/pedc_energy_window.sv
/*
 Retriggerable window timer: reports energy seen within the last
 window of cycles. Assumes its energy input is already synchronous.
*/
`timescale 1ns/100ps
module pedc_energy_window
   import pedc_pkg::*;
#(
   parameter int unsigned WINDOW_CYC = ENERGY_WINDOW_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Energy pulse in, windowed flag out
   input wire logic i_energy,
   output logic o_seen
);
   localparam int unsigned CW = $clog2(WINDOW_CYC + 1);
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic seen;
   logic next_seen;

   // A zero-length window could never report energy; refuse it at elaboration
   if (WINDOW_CYC < 1) begin : g_bad_window
      $error("Window must be at least one cycle");
   end

   // Reload on energy, count down otherwise; flag falls at expiry
   always_comb begin
      next_count = count;
      next_seen = seen;
      if (i_energy) begin
         next_count = CW'(WINDOW_CYC);
         next_seen = 1'b1;
      end else if (count != '0) begin
         next_count = count - CW'(1);
         next_seen = (count != CW'(1));
      end else begin
         next_seen = 1'b0;
      end
   end

   // Flag resets high so a fresh device wakes listening
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count <= CW'(WINDOW_CYC);
         seen <= 1'b1;
      end else begin
         count <= next_count;
         seen <= next_seen;
      end
   end

   assign o_seen = seen;
endmodule

//--- tb/pedc_top_props.sv
/*
 Port checker for the energy-detect control block.
 Assumes it is bound to pedc_top and shares its window length.
*/
`timescale 1ns/100ps
module pedc_top_props
   import pedc_pkg::*;
#(
   parameter int unsigned WINDOW_CYC = ENERGY_WINDOW_CYC
) (
   // Clock, reset, register port
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   // Front end and transmit side
   input wire logic i_energy_raw,
   input wire logic i_link_raw,
   input wire logic i_speed_100,
   input wire logic i_transmit_request,
   input wire logic o_transmit_grant,
   input wire logic o_phy_power_on,
   input wire logic o_thres_low,
   input wire logic o_link_up,
   input wire logic o_irq
);
   int unsigned quiet;
   logic [1:0] energy_pipe;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // Energy delayed by the block's two sync stages, so quiet lines up with the reload
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         energy_pipe <= 2'h0;
      end else begin
         energy_pipe <= {energy_pipe[0], i_energy_raw};
      end
   end
   // Cycles since energy reached the window timer; saturates so it never wraps
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         quiet <= 0;
      end else if (energy_pipe[1]) begin
         quiet <= 0;
      end else if (quiet < 1000) begin
         quiet <= quiet + 1;
      end
   end
   sequence ctl_read;
      i_rd && i_addr == OFS_CONTROL;
   endsequence
   sequence line_slow;
      (!i_link_raw && !i_speed_100) [*3];
   endsequence
   a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_thres_follows_write: assert property (
      $past(i_wr) && $past(i_addr) == OFS_CONTROL
      |-> o_thres_low == $past(i_wdata[BIT_THRES_LOW]))
      else $error("threshold output does not follow write");
   a_reserved_read_zero: assert property (ctl_read |=> (o_rdata & 16'hD7F9) == 16'h0000)
      else $error("reserved control bits read nonzero");
   a_flag_recent_high: assert property (
      i_rd && i_addr == OFS_CONTROL && quiet + 2 < WINDOW_CYC |=> o_rdata[1])
      else $error("energy flag low despite recent energy");
   a_flag_stale_low: assert property (
      i_rd && i_addr == OFS_CONTROL && quiet > WINDOW_CYC + 4 |=> !o_rdata[1])
      else $error("energy flag high after quiet window");
   a_wake_on_energy: assert property (i_energy_raw |-> ##[1:5] o_phy_power_on)
      else $error("phy not powered after energy");
   a_link_unforced_low: assert property (line_slow |=> !o_link_up)
      else $error("link up without link or 100 Mbps");
   a_grant_has_cause: assert property (
      o_transmit_grant |-> $past(i_transmit_request && o_link_up && o_phy_power_on))
      else $error("transmit granted while held off");
   a_irq_masked_off: assert property ($past(i_wr) && $past(i_addr) == OFS_IRQ_MASK
      && $past(i_wdata[2:0]) == 3'h0 |-> !o_irq)
      else $error("interrupt high with mask cleared");
endmodule
bind pedc_top pedc_top_props #(.WINDOW_CYC(WINDOW_CYC)) pedc_top_props_inst (
   .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_energy_raw(i_energy_raw), .i_link_raw(i_link_raw),
   .i_speed_100(i_speed_100), .i_transmit_request(i_transmit_request),
   .o_transmit_grant(o_transmit_grant), .o_phy_power_on(o_phy_power_on),
   .o_thres_low(o_thres_low), .o_link_up(o_link_up), .o_irq(o_irq));

//--- tb/pedc_medium_model.sv
/*
 Twisted-pair medium with a link partner that sends link pulses.
 Assumes the bench decides when the cable is attached and linked.
*/
`timescale 1ns/100ps
module pedc_medium_model (
   // Bench controls
   input wire logic i_clk,
   input wire logic i_attached,
   input wire logic i_linked,
   input wire logic i_fast,
   // Front end view of the line
   output logic o_energy,
   output logic o_link,
   output logic o_speed_100
);
   // Pulses off the core edge, so the block must synchronise them
   initial o_energy = 1'b0;
   always @(negedge i_clk) begin
      o_energy <= i_attached && !o_energy;
   end
   // Link only means something while a cable is present; speed follows i_fast with or without a cable
   assign o_link = i_attached && i_linked;
   assign o_speed_100 = i_fast;
endmodule

//--- tb/pedc_top_test.sv
/*
 Register-level bench for the energy-detect control block.
 Assumes the medium model drives the front end inputs.
*/
`timescale 1ns/100ps
module pedc_top_test;
   import pedc_pkg::*;
   localparam int unsigned WIN = 16;
   logic i_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, tx = 1'b0;
   logic cable = 1'b1, linked = 1'b0, fast = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic [15:0] o_rdata;
   logic energy, link, speed, o_grant, o_pwr, o_thr, o_link_up, o_irq;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   pedc_medium_model pedc_medium_model_inst (.i_clk(i_clk), .i_attached(cable),
      .i_linked(linked), .i_fast(fast), .o_energy(energy), .o_link(link), .o_speed_100(speed));
   pedc_top #(.WINDOW_CYC(WIN)) pedc_top_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_energy_raw(energy), .i_link_raw(link), .i_speed_100(speed),
      .i_transmit_request(tx), .o_transmit_grant(o_grant), .o_phy_power_on(o_pwr),
      .o_thres_low(o_thr), .o_link_up(o_link_up), .o_irq(o_irq));
   // 40 MHz clock
   initial begin
      forever #12.5 i_clk = ~i_clk;
   end
   // Hang guard well above the roughly 120 cycles the tests need
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   // Read data is only valid in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic c);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      if (c) check(o_rdata, e);
   endtask
   task automatic do_reset();
      i_arst_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
   endtask
   task automatic print_verdict();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      do_reset();
      rd(OFS_CONTROL, 16'h0002, 1'b1);
      rd(4'hF, 16'h0000, 1'b1);
      wr(OFS_CONTROL, 16'hFFFF);
      rd(OFS_CONTROL, 16'h2806, 1'b1);
      check(16'(o_thr), 16'h0001);
      fast <= 1'b1;
      repeat (4) @(posedge i_clk);
      check(16'(o_link_up), 16'h0001);
      fast <= 1'b0;
      repeat (4) @(posedge i_clk);
      check(16'(o_link_up), 16'h0000);
      fast <= 1'b1;
      wr(OFS_IRQ_MASK, 16'h0007);
      repeat (4) @(posedge i_clk);
      rd(OFS_IRQ_STATUS, 16'h0000, 1'b0);
      check(16'(o_irq), 16'h0000);
      @(posedge i_clk);
      cable <= 1'b0;
      tx <= 1'b1;
      repeat (WIN + 8) @(posedge i_clk);
      wr(OFS_CONTROL, 16'h2806);
      rd(OFS_CONTROL, 16'h2804, 1'b1);
      rd(OFS_LINK_STATE, 16'h0007, 1'b1);
      check(16'(o_pwr), 16'h0000);
      check(16'(o_grant), 16'h0000);
      check(16'(o_irq), 16'h0001);
      wr(OFS_IRQ_MASK, 16'h0000);
      check(16'(o_irq), 16'h0000);
      wr(OFS_IRQ_MASK, 16'h0007);
      check(16'(o_irq), 16'h0001);
      rd(OFS_IRQ_STATUS, 16'h0002, 1'b1);
      check(16'(o_irq), 16'h0000);
      cable <= 1'b1;
      repeat (8) @(posedge i_clk);
      check(16'(o_pwr), 16'h0001);
      check(16'(o_grant), 16'h0001);
      wr(OFS_CONTROL, 16'h0800);
      cable <= 1'b0;
      repeat (WIN + 8) @(posedge i_clk);
      check(16'(o_pwr), 16'h0001);
      cable <= 1'b1;
      linked <= 1'b1;
      fast <= 1'b0;
      repeat (6) @(posedge i_clk);
      check(16'(o_link_up), 16'h0001);
      check(16'(o_grant), 16'h0001);
      cable <= 1'b0;
      do_reset();
      rd(OFS_CONTROL, 16'h0002, 1'b1);
      check(16'(o_thr), 16'h0000);
      print_verdict();
   end
endmodule
